//--- bench/bit_branch_xor_call_exec_properties.sv
// Concurrent checks on execution time, stack pushes and flag updates of the unit.
`timescale 1ns/100ps
module bit_branch_xor_call_exec_properties
  import exec_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic start_i,
  input wire logic [7:0] opcode_i,
  input wire logic [15:0] pc_i,
  input wire logic [15:0] sp_i,
  input wire logic [7:0] flags_i,
  input wire logic busy_o,
  input wire logic done_o,
  input wire logic reject_o,
  input wire logic stack_we_o,
  input wire logic [15:0] stack_addr_o,
  input wire logic [7:0] stack_wdata_o,
  input wire logic pc_load_o,
  input wire logic [15:0] sp_o,
  input wire logic sp_load_o,
  input wire logic [7:0] flags_o,
  input wire logic flags_we_o
);
  logic take;
  logic known;
  logic [7:0] last_op;
  logic [15:0] saved_pc;
  logic [15:0] saved_sp;
  logic [7:0] saved_flags;
  logic [15:0] ret_pc;
  // The unit is idle again in its done cycle, so a start there is taken as well.
  assign take = start_i && !busy_o;
  assign known = opcode_i inside {OPC_BIT_JUMP, OPC_BIT_XOR, OPC_CALL_DIRECT, OPC_CALL_PAIR,
    OPC_CALL_VECTOR};
  assign ret_pc = saved_pc + ((last_op == OPC_CALL_DIRECT) ? LEN_CALL_DIRECT : LEN_CALL_PAIR);
  // Inputs may move during execution, so the operands are kept from the accepting edge.
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      last_op <= 8'h00;
      saved_pc <= 16'h0000;
      saved_sp <= 16'h0000;
      saved_flags <= 8'h00;
    end else if (take) begin
      last_op <= opcode_i;
      saved_pc <= pc_i;
      saved_sp <= sp_i;
      saved_flags <= flags_i;
    end
  end
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!rst_n_i);
  sequence s_take(logic [7:0] op);
    take && opcode_i == op;
  endsequence
  sequence s_push_pair;
    stack_we_o && stack_addr_o == saved_sp - SP_STEP_ONE && stack_wdata_o == ret_pc[7:0]
    ##1 stack_we_o && stack_addr_o == saved_sp - SP_STEP_TWO && stack_wdata_o == ret_pc[15:8];
  endsequence
  chk_jump_ten_cycles: assert property (s_take(OPC_BIT_JUMP) |-> ##10 done_o && pc_load_o)
    else $error("bit jump did not end after ten cycles");
  chk_xor_six_cycles: assert property (s_take(OPC_BIT_XOR) |-> ##6 done_o && flags_we_o)
    else $error("bit xor did not end after six cycles");
  chk_call_direct_time: assert property (s_take(OPC_CALL_DIRECT) |-> ##14 done_o && sp_load_o)
    else $error("direct call did not end after fourteen cycles");
  chk_call_pair_time: assert property (s_take(OPC_CALL_PAIR) |-> ##12 done_o && sp_load_o)
    else $error("pair call did not end after twelve cycles");
  chk_call_vector_time: assert property (s_take(OPC_CALL_VECTOR) |-> ##14 done_o && pc_load_o)
    else $error("vector call did not end after fourteen cycles");
  chk_push_direct_order: assert property (s_take(OPC_CALL_DIRECT) |-> ##2 s_push_pair)
    else $error("direct call push order or data wrong");
  chk_push_indirect_order: assert property (take && (opcode_i == OPC_CALL_PAIR ||
      opcode_i == OPC_CALL_VECTOR) |-> ##5 s_push_pair)
    else $error("indirect call push order or data wrong");
  chk_call_sp_value: assert property (sp_load_o |-> done_o && sp_o == saved_sp - SP_STEP_TWO)
    else $error("stack pointer not lowered by two");
  chk_flags_xor_only: assert property (flags_we_o |-> done_o && last_op == OPC_BIT_XOR)
    else $error("flags written by a branch or call");
  chk_xor_flag_bits: assert property (flags_we_o |-> !flags_o[FLAG_S] &&
      flags_o[FLAG_C] == saved_flags[FLAG_C] && flags_o[FLAG_D] == saved_flags[FLAG_D] &&
      flags_o[FLAG_H] == saved_flags[FLAG_H])
    else $error("bit xor flag update wrong");
  chk_reject_pulse: assert property (take && !known |-> ##1 reject_o && !busy_o ##1 !reject_o)
    else $error("unknown opcode not rejected with one pulse");
  chk_done_single: assert property (done_o |=> !done_o)
    else $error("done longer than one cycle");
endmodule : bit_branch_xor_call_exec_properties

bind bit_branch_xor_call_exec bit_branch_xor_call_exec_properties u_props (.ref_clk_i, .rst_n_i,
  .start_i, .opcode_i, .pc_i, .sp_i, .flags_i, .busy_o, .done_o, .reject_o, .stack_we_o,
  .stack_addr_o, .stack_wdata_o, .pc_load_o, .sp_o, .sp_load_o, .flags_o, .flags_we_o);

//--- bench/bit_branch_xor_call_exec_tb_top.sv
// Directed testbench for the bit-branch, bit-XOR and call execution unit.
`timescale 1ns/100ps
module bit_branch_xor_call_exec_tb_top;
  import exec_pkg::*;
  logic ref_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic start_i = 1'b0;
  logic [7:0] opcode_i = 8'h00;
  logic [7:0] operand1_i = 8'h00;
  logic [7:0] operand2_i = 8'h00;
  logic [15:0] pc_i = 16'h0000;
  logic [15:0] sp_i = 16'h0000;
  logic [7:0] flags_i = 8'h00;
  logic [7:0] reg_rdata_i = 8'h00;
  logic [7:0] pmem_rdata_i = 8'h00;
  logic busy_o, done_o, reject_o, reg_working_o, reg_rd_o, reg_we_o, pmem_rd_o, stack_we_o;
  logic pc_load_o, sp_load_o, flags_we_o;
  logic [7:0] reg_addr_o, reg_wdata_o, stack_wdata_o, flags_o;
  logic [15:0] pmem_addr_o, stack_addr_o, pc_o, sp_o;
  int miscompares = 0;
  int tests_run = 0;
  logic [7:0] wreg [0:15];
  logic [7:0] regs [0:255];
  logic [7:0] pmem [0:255];
  logic [7:0] stk [0:15];

  bit_branch_xor_call_exec u_dut (.ref_clk_i, .rst_n_i, .start_i, .opcode_i, .operand1_i,
    .operand2_i, .pc_i, .sp_i, .flags_i, .reg_rdata_i, .pmem_rdata_i, .busy_o, .done_o,
    .reject_o, .reg_addr_o, .reg_working_o, .reg_rd_o, .reg_we_o, .reg_wdata_o, .pmem_addr_o,
    .pmem_rd_o, .stack_we_o, .stack_addr_o, .stack_wdata_o, .pc_o, .pc_load_o, .sp_o,
    .sp_load_o, .flags_o, .flags_we_o);

  initial begin
    forever #5 ref_clk_i = ~ref_clk_i;
  end

  // Idle read data toggles so that a read taken a cycle late cannot match by chance.
  always @(posedge ref_clk_i) begin
    if (reg_rd_o === 1'b1)
      reg_rdata_i <= #1 (reg_working_o === 1'b1) ? wreg[reg_addr_o[3:0]] : regs[reg_addr_o];
    else
      reg_rdata_i <= #1 ~reg_rdata_i;
    if (pmem_rd_o === 1'b1)
      pmem_rdata_i <= #1 pmem[pmem_addr_o[7:0]];
    else
      pmem_rdata_i <= #1 ~pmem_rdata_i;
    if (reg_we_o === 1'b1 && reg_working_o === 1'b1)
      wreg[reg_addr_o[3:0]] <= reg_wdata_o;
    if (reg_we_o === 1'b1 && reg_working_o === 1'b0)
      regs[reg_addr_o] <= reg_wdata_o;
    if (stack_we_o === 1'b1)
      stk[stack_addr_o[3:0]] <= stack_wdata_o;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %0t: got %h want %h", $time, seen, exp);
    end
  endtask : check

  task automatic complete_run;
    $display("Comparisons %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : complete_run

  // Starts one instruction, counts cycles to done and checks the result of that cycle.
  task automatic run_op(input logic [7:0] op, input logic [7:0] o1, input logic [7:0] o2,
    input logic [15:0] pc, input logic [15:0] exp_pc, input logic [15:0] cyc);
    logic [15:0] n;
    opcode_i = op;
    operand1_i = o1;
    operand2_i = o2;
    pc_i = pc;
    start_i = 1'b1;
    @(posedge ref_clk_i);
    #1;
    start_i = 1'b0;
    // The accepting edge is cycle one; the next instruction may be taken n edges after it.
    n = 16'h0001;
    while (done_o !== 1'b1 && n < 16'h0040) begin
      @(posedge ref_clk_i);
      #1;
      n = n + 16'h0001;
    end
    check(n, cyc);
    check(pc_o, exp_pc);
    check(16'(flags_we_o), 16'(op == OPC_BIT_XOR));
    @(posedge ref_clk_i);
    #1;
  endtask : run_op

  task automatic t_bit_jump;
    logic [7:0] d;
    logic s;
    logic b;
    logic [15:0] e;
    wreg[5] = 8'h0a;
    for (int k = 0; k < 8; k++) begin
      s = k[2];
      b = k[1];
      d = k[0] ? 8'h80 : 8'h7f;
      e = 16'h2003 + ((b == s) ? {{8{d[7]}}, d} : 16'h0000);
      run_op(OPC_BIT_JUMP, {4'h5, 2'b01, b, s}, d, 16'h2000, e, 16'd10);
    end
  endtask : t_bit_jump

  task automatic t_bit_xor;
    wreg[1] = 8'h07;
    regs[1] = 8'h03;
    flags_i = 8'hff;
    run_op(OPC_BIT_XOR, 8'h12, 8'h01, 16'h3000, 16'h3003, 16'd6);
    check(16'(wreg[1]), 16'h0006);
    check(16'(regs[1]), 16'h0003);
    check(16'(flags_o & 8'hec), 16'h00cc);
    wreg[1] = 8'h07;
    flags_i = 8'h20;
    run_op(OPC_BIT_XOR, 8'h15, 8'h01, 16'h3000, 16'h3003, 16'd6);
    check(16'(regs[1]), 16'h0007);
    check(16'(wreg[1]), 16'h0007);
    check(16'(flags_o & 8'hec), 16'h0000);
  endtask : t_bit_xor

  task automatic call_one(input logic [7:0] op, input logic [7:0] o1, input logic [15:0] cyc,
    input logic [7:0] lo);
    for (int i = 0; i < 16; i++) stk[i] = 8'h55;
    run_op(op, o1, 8'h21, 16'h1a47, 16'h3521, cyc);
    check(16'(stk[1]), 16'(lo));
    check(16'(stk[0]), 16'h001a);
    check(sp_o, 16'h0000);
  endtask : call_one

  task automatic t_calls;
    sp_i = 16'h0002;
    regs[8'h10] = 8'h35;
    regs[8'h11] = 8'h21;
    pmem[8'h40] = 8'h35;
    pmem[8'h41] = 8'h21;
    call_one(OPC_CALL_DIRECT, 8'h35, 16'd14, 8'h4a);
    call_one(OPC_CALL_PAIR, 8'h10, 16'd12, 8'h49);
    call_one(OPC_CALL_VECTOR, 8'h40, 16'd14, 8'h49);
  endtask : t_calls

  task automatic t_reject;
    opcode_i = 8'h00;
    start_i = 1'b1;
    @(posedge ref_clk_i);
    #1;
    // Start stays high, so the branch below is offered at the very next edge.
    check(16'(reject_o), 16'h0001);
    check(16'(busy_o), 16'h0000);
    run_op(OPC_BIT_JUMP, 8'h50, 8'h10, 16'h2000, 16'h2013, 16'd10);
  endtask : t_reject

  initial begin
    for (int i = 0; i < 256; i++) regs[i] = 8'h00;
    for (int i = 0; i < 256; i++) pmem[i] = 8'h00;
    for (int i = 0; i < 16; i++) wreg[i] = 8'h00;
    repeat (10) @(posedge ref_clk_i);
    #1;
    rst_n_i = 1'b1;
    t_bit_jump();
    t_bit_xor();
    t_calls();
    t_reject();
    complete_run();
  end

  // The whole sequence needs well under 300 cycles; this span only catches a hang.
  initial begin
    #20000;
    miscompares++;
    complete_run();
  end
endmodule : bit_branch_xor_call_exec_tb_top

//--- logic/bit_branch_xor_call_exec.sv
// Execution unit for bit-test branches, single-bit exclusive-OR and subroutine calls.
// Operation
// RULE1: Jump-if-bit-clear adds displacement when bit zero.
// RULE2: Jump-if-bit-set adds displacement when bit one.
// RULE3: Opcode 37, three bytes, ten cycles, sense bit.
// RULE4: Displacement is a signed byte.
// RULE5: Branches and calls never change flags.
// RULE6: Bit XOR writes only the destination bit.
// RULE7: Bit XOR sets Z, clears S, keeps others.
// RULE8: Opcode 27, six cycles, form bit swaps roles.
// RULE9: Call pushes low byte, then high byte.
// RULE10: Pushed address follows the call instruction.
// RULE11: Call forms F6, F4, D4 with their timings.
// RULE12: Vector form reads high then low byte.
// RULE13: Displacement adds to address past branch.
`timescale 1ns/100ps
module bit_branch_xor_call_exec (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic start_i,
  input wire logic [7:0] opcode_i,
  input wire logic [7:0] operand1_i,
  input wire logic [7:0] operand2_i,
  input wire logic [15:0] pc_i,
  input wire logic [15:0] sp_i,
  input wire logic [7:0] flags_i,
  input wire logic [7:0] reg_rdata_i,
  input wire logic [7:0] pmem_rdata_i,
  output logic busy_o,
  output logic done_o,
  output logic reject_o,
  output logic [7:0] reg_addr_o,
  output logic reg_working_o,
  output logic reg_rd_o,
  output logic reg_we_o,
  output logic [7:0] reg_wdata_o,
  output logic [15:0] pmem_addr_o,
  output logic pmem_rd_o,
  output logic stack_we_o,
  output logic [15:0] stack_addr_o,
  output logic [7:0] stack_wdata_o,
  output logic [15:0] pc_o,
  output logic pc_load_o,
  output logic [15:0] sp_o,
  output logic sp_load_o,
  output logic [7:0] flags_o,
  output logic flags_we_o
);
  import exec_pkg::*;
  exec_state_e state, next_state;
  op_kind_e kind, next_kind;
  logic [7:0] byte2, next_byte2, byte3, next_byte3, first_byte, next_first_byte;
  logic [7:0] flags_q, next_flags_q, res_flags, next_res_flags, rd_data, merged;
  logic [7:0] next_reg_addr, next_reg_wdata, next_stack_wdata, next_flags;
  logic [15:0] ret_pc, next_ret_pc, sp_q, next_sp_q, target, next_target, res_pc, next_res_pc;
  logic [15:0] next_pmem_addr, next_stack_addr, next_pc, next_sp;
  logic next_busy, next_done, next_reject, next_reg_working, next_reg_rd, next_reg_we;
  logic next_pmem_rd, next_stack_we, next_pc_load, next_sp_load, next_flags_we;
  logic timer_load, timer_expire, tested_bit, result_bit;
  logic [TIMER_W-1:0] timer_val;
  logic [2:0] bit_idx;
  cycle_timer #(.WIDTH(TIMER_W)) u_timer (
    .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
    .load_i(timer_load), .load_val_i(timer_val),
    .expire_o(timer_expire)
  );
  always_comb begin
    next_state = state;
    next_kind = kind;
    next_byte2 = byte2;
    next_byte3 = byte3;
    next_ret_pc = ret_pc;
    next_sp_q = sp_q;
    next_flags_q = flags_q;
    next_first_byte = first_byte;
    next_target = target;
    next_res_pc = res_pc;
    next_res_flags = res_flags;
    next_done = 1'b0;
    next_reject = 1'b0;
    next_reg_addr = reg_addr_o;
    next_reg_working = reg_working_o;
    next_reg_rd = 1'b0;
    next_reg_we = 1'b0;
    next_reg_wdata = reg_wdata_o;
    next_pmem_addr = pmem_addr_o;
    next_pmem_rd = 1'b0;
    next_stack_we = 1'b0;
    next_stack_addr = stack_addr_o;
    next_stack_wdata = stack_wdata_o;
    next_pc = pc_o;
    next_pc_load = 1'b0;
    next_sp = sp_o;
    next_sp_load = 1'b0;
    next_flags = flags_o;
    next_flags_we = 1'b0;
    timer_load = 1'b0;
    timer_val = '0;
    rd_data = (kind == K_CALL_VECTOR) ? pmem_rdata_i : reg_rdata_i;
    bit_idx = byte2[FLD_BIT_HI:FLD_BIT_LO];
    tested_bit = rd_data[bit_idx];
    result_bit = first_byte[0] ^ tested_bit; // RULE6
    merged = rd_data;
    merged[bit_idx] = result_bit; // RULE6
    case (state)
      ST_IDLE: begin
        if (start_i) begin
          next_byte2 = operand1_i;
          next_byte3 = operand2_i;
          next_sp_q = sp_i;
          next_flags_q = flags_i;
          timer_load = 1'b1;
          next_state = ST_ADDR1;
          next_reg_addr = {4'h0, operand1_i[FLD_REG_HI:FLD_REG_LO]};
          next_reg_working = 1'b1;
          next_reg_rd = 1'b1;
          if (opcode_i == OPC_BIT_JUMP) begin
            next_kind = K_BIT_JUMP;
            next_ret_pc = pc_i + LEN_BIT_JUMP; // RULE13
            timer_val = CYC_BIT_JUMP - CYC_ONE; // RULE3
          end else if (opcode_i == OPC_BIT_XOR) begin
            next_kind = K_BIT_XOR;
            next_ret_pc = pc_i + LEN_BIT_XOR;
            timer_val = CYC_BIT_XOR - CYC_ONE; // RULE8
          end else if (opcode_i == OPC_CALL_DIRECT) begin
            next_kind = K_CALL_DIRECT;
            next_ret_pc = pc_i + LEN_CALL_DIRECT; // RULE10
            next_target = {operand1_i, operand2_i};
            timer_val = CYC_CALL_DIRECT - CYC_ONE; // RULE11
            next_reg_rd = 1'b0;
            next_state = ST_PUSH_LO;
          end else if (opcode_i == OPC_CALL_PAIR) begin
            next_kind = K_CALL_PAIR;
            next_ret_pc = pc_i + LEN_CALL_PAIR; // RULE10
            timer_val = CYC_CALL_PAIR - CYC_ONE; // RULE11
            next_reg_addr = operand1_i;
            next_reg_working = 1'b0;
          end else if (opcode_i == OPC_CALL_VECTOR) begin
            next_kind = K_CALL_VECTOR;
            next_ret_pc = pc_i + LEN_CALL_VECTOR; // RULE10
            timer_val = CYC_CALL_VECTOR - CYC_ONE; // RULE11
            next_reg_rd = 1'b0;
            next_pmem_addr = {8'h00, operand1_i}; // RULE12
            next_pmem_rd = 1'b1;
          end else begin
            // Unknown opcodes belong to other execution units and are bounced at once.
            next_reg_rd = 1'b0;
            next_reject = 1'b1;
            next_state = ST_IDLE;
          end
        end
      end
      ST_ADDR1: begin
        next_res_pc = ret_pc;
        next_state = ST_DATA1;
        if (kind == K_BIT_XOR) begin
          next_reg_addr = byte3;
          next_reg_working = 1'b0;
          next_reg_rd = 1'b1;
        end else if (kind == K_CALL_PAIR) begin
          next_reg_addr = reg_addr_o + PAIR_STEP;
          next_reg_rd = 1'b1;
        end else if (kind == K_CALL_VECTOR) begin
          next_pmem_addr = {8'h00, byte2 + PAIR_STEP}; // RULE12
          next_pmem_rd = 1'b1;
        end
      end
      ST_DATA1: begin
        next_first_byte = rd_data;
        next_state = ST_DATA2;
        if (kind == K_BIT_JUMP) begin
          next_state = ST_WAIT;
          // Sense bit low jumps on a clear bit, high on a set bit.
          if (tested_bit == byte2[FLD_FORM]) begin // RULE1 RULE2 RULE3
            next_res_pc = ret_pc + {{8{byte3[7]}}, byte3}; // RULE4 RULE13
          end
        end
      end
      ST_DATA2: begin
        next_state = ST_PUSH_LO;
        if (kind == K_BIT_XOR) begin
          next_state = ST_WAIT;
          next_reg_we = 1'b1;
          if (byte2[FLD_FORM] == 1'b0) begin // RULE8
            next_reg_addr = {4'h0, byte2[FLD_REG_HI:FLD_REG_LO]};
            next_reg_working = 1'b1;
            next_reg_wdata = {first_byte[7:1], result_bit}; // RULE6
          end else begin
            next_reg_addr = byte3;
            next_reg_working = 1'b0;
            next_reg_wdata = merged; // RULE6
          end
          // Overflow is left as it was; the other untouched flags keep their values.
          next_res_flags = flags_q;
          next_res_flags[FLAG_Z] = ~result_bit; // RULE7
          next_res_flags[FLAG_S] = 1'b0; // RULE7
        end else begin
          next_target = {first_byte, rd_data}; // RULE12
        end
      end
      ST_PUSH_LO: begin
        next_stack_we = 1'b1;
        next_stack_addr = sp_q - SP_STEP_ONE; // RULE9
        next_stack_wdata = ret_pc[7:0]; // RULE9 RULE10
        next_state = ST_PUSH_HI;
      end
      ST_PUSH_HI: begin
        next_stack_we = 1'b1;
        next_stack_addr = sp_q - SP_STEP_TWO; // RULE9
        next_stack_wdata = ret_pc[15:8]; // RULE9 RULE10
        next_res_pc = target; // RULE9
        next_state = ST_WAIT;
      end
      ST_WAIT: begin
        if (timer_expire) begin
          next_done = 1'b1;
          next_pc = res_pc;
          next_pc_load = 1'b1;
          next_state = ST_IDLE;
          if (kind == K_BIT_XOR) begin
            next_flags = res_flags;
            next_flags_we = 1'b1; // RULE5 RULE7
          end else if (kind != K_BIT_JUMP) begin
            next_sp = sp_q - SP_STEP_TWO; // RULE9
            next_sp_load = 1'b1;
          end
        end
      end
      default: next_state = ST_IDLE;
    endcase
    next_busy = (next_state != ST_IDLE);
  end
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state <= ST_IDLE;
      kind <= K_BIT_JUMP;
      byte2 <= 8'h00;
      byte3 <= 8'h00;
      ret_pc <= 16'h0000;
      sp_q <= 16'h0000;
      flags_q <= 8'h00;
      first_byte <= 8'h00;
      target <= 16'h0000;
      res_pc <= 16'h0000;
      res_flags <= 8'h00;
      busy_o <= 1'b0;
      done_o <= 1'b0;
      reject_o <= 1'b0;
      reg_addr_o <= 8'h00;
      reg_working_o <= 1'b0;
      reg_rd_o <= 1'b0;
      reg_we_o <= 1'b0;
      reg_wdata_o <= 8'h00;
      pmem_addr_o <= 16'h0000;
      pmem_rd_o <= 1'b0;
      stack_we_o <= 1'b0;
      stack_addr_o <= 16'h0000;
      stack_wdata_o <= 8'h00;
      pc_o <= 16'h0000;
      pc_load_o <= 1'b0;
      sp_o <= 16'h0000;
      sp_load_o <= 1'b0;
      flags_o <= 8'h00;
      flags_we_o <= 1'b0;
    end else begin
      state <= next_state;
      kind <= next_kind;
      byte2 <= next_byte2;
      byte3 <= next_byte3;
      ret_pc <= next_ret_pc;
      sp_q <= next_sp_q;
      flags_q <= next_flags_q;
      first_byte <= next_first_byte;
      target <= next_target;
      res_pc <= next_res_pc;
      res_flags <= next_res_flags;
      busy_o <= next_busy;
      done_o <= next_done;
      reject_o <= next_reject;
      reg_addr_o <= next_reg_addr;
      reg_working_o <= next_reg_working;
      reg_rd_o <= next_reg_rd;
      reg_we_o <= next_reg_we;
      reg_wdata_o <= next_reg_wdata;
      pmem_addr_o <= next_pmem_addr;
      pmem_rd_o <= next_pmem_rd;
      stack_we_o <= next_stack_we;
      stack_addr_o <= next_stack_addr;
      stack_wdata_o <= next_stack_wdata;
      pc_o <= next_pc;
      pc_load_o <= next_pc_load;
      sp_o <= next_sp;
      sp_load_o <= next_sp_load;
      flags_o <= next_flags;
      flags_we_o <= next_flags_we;
    end
  end
endmodule : bit_branch_xor_call_exec

//--- logic/cycle_timer.sv
// Down-counter that marks the cycle before the last of an instruction's execution time.
`timescale 1ns/100ps
module cycle_timer #(
  parameter int unsigned WIDTH = 4
) (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic load_i,
  input wire logic [WIDTH-1:0] load_val_i,
  output logic expire_o
);
  logic [WIDTH-1:0] count;
  logic [WIDTH-1:0] next_count;

  always_comb begin
    next_count = count;
    if (load_i) begin
      next_count = load_val_i;
    end else if (count != '0) begin
      next_count = count - WIDTH'(1);
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      count <= '0;
    end else begin
      count <= next_count;
    end
  end

  assign expire_o = (count == WIDTH'(1));
endmodule : cycle_timer

//--- shared/exec_pkg.sv
// Constants, encodings and state types for the bit-branch, bit-XOR and call execution unit.
package exec_pkg;
  localparam int unsigned TIMER_W = 4;

  // Opcodes served by the unit.
  localparam logic [7:0] OPC_BIT_JUMP = 8'h37;
  localparam logic [7:0] OPC_BIT_XOR = 8'h27;
  localparam logic [7:0] OPC_CALL_DIRECT = 8'hf6;
  localparam logic [7:0] OPC_CALL_PAIR = 8'hf4;
  localparam logic [7:0] OPC_CALL_VECTOR = 8'hd4;

  // Instruction lengths in bytes.
  localparam logic [15:0] LEN_BIT_JUMP = 16'h0003;
  localparam logic [15:0] LEN_BIT_XOR = 16'h0003;
  localparam logic [15:0] LEN_CALL_DIRECT = 16'h0003;
  localparam logic [15:0] LEN_CALL_PAIR = 16'h0002;
  localparam logic [15:0] LEN_CALL_VECTOR = 16'h0002;

  // Execution times in core clock cycles.
  localparam logic [TIMER_W-1:0] CYC_BIT_JUMP = 4'ha;
  localparam logic [TIMER_W-1:0] CYC_BIT_XOR = 4'h6;
  localparam logic [TIMER_W-1:0] CYC_CALL_DIRECT = 4'he;
  localparam logic [TIMER_W-1:0] CYC_CALL_PAIR = 4'hc;
  localparam logic [TIMER_W-1:0] CYC_CALL_VECTOR = 4'he;
  localparam logic [TIMER_W-1:0] CYC_ONE = 4'h1;

  // Second instruction byte layout: register nibble, bit index, form or sense bit.
  localparam int unsigned FLD_REG_HI = 7;
  localparam int unsigned FLD_REG_LO = 4;
  localparam int unsigned FLD_BIT_HI = 3;
  localparam int unsigned FLD_BIT_LO = 1;
  localparam int unsigned FLD_FORM = 0;

  // Condition flag positions.
  localparam int unsigned FLAG_C = 7;
  localparam int unsigned FLAG_Z = 6;
  localparam int unsigned FLAG_S = 5;
  localparam int unsigned FLAG_V = 4;
  localparam int unsigned FLAG_D = 3;
  localparam int unsigned FLAG_H = 2;

  // Stack moves down by two bytes per call.
  localparam logic [15:0] SP_STEP_ONE = 16'h0001;
  localparam logic [15:0] SP_STEP_TWO = 16'h0002;
  localparam logic [7:0] PAIR_STEP = 8'h01;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR1,
    ST_DATA1,
    ST_DATA2,
    ST_PUSH_LO,
    ST_PUSH_HI,
    ST_WAIT
  } exec_state_e;

  typedef enum logic [2:0] {
    K_BIT_JUMP,
    K_BIT_XOR,
    K_CALL_DIRECT,
    K_CALL_PAIR,
    K_CALL_VECTOR
  } op_kind_e;
endpackage : exec_pkg
